// File: hdl/ucg_pkg.sv
// Constants, types and helpers shared by the upper channel gain register block.
// Function
// [R1] Bits 14:12 give channel 7 gain code.
// [R2] Bits 10:8 give channel 6 gain code.
// [R3] Bits 6:4 give channel 5 gain code.
// [R4] Bits 2:0 give channel 4 gain code.
// [R5] All gain codes reset to unity gain.
// [R6] Software writes zero into reserved bits.
// [R7] Register sits at address 5h, resets 0000h.
// [R8] Reads return last written codes; codes drive outputs.
package ucg_pkg;

  // Register port geometry.
  localparam int ADDR_W = 6;
  localparam int DATA_W = 16;

  // Gain code and decoded gain factor widths.
  localparam int CODE_W = 3;
  localparam int GAIN_W = 8;
  localparam int NUM_CH = 4;

  // Register addresses on the plain register port.
  localparam logic [ADDR_W-1:0] UCG_GAIN_ADDR = 6'h05;
  localparam logic [ADDR_W-1:0] UCG_STAT_ADDR = 6'h3f;

  // Whole register reset value and reset gain code.
  localparam logic [DATA_W-1:0] UCG_GAIN_RESET = 16'h0000;
  localparam logic [CODE_W-1:0] CODE_RESET     = 3'h0;

  // Reserved bit positions 15, 11, 7 and 3.
  localparam logic [DATA_W-1:0] RSVD_MASK = 16'h8888;

  // Status register bit for a write that carried nonzero reserved bits.
  localparam int STAT_RSVD_BIT = 0;

  // Unity gain factor, shifted left by the gain code.
  localparam logic [GAIN_W-1:0] GAIN_UNITY = 8'h01;

  // Register layout, most significant field first.
  typedef struct packed {
    logic              rsvd15;
    logic [CODE_W-1:0] ch7_gain_code;
    logic              rsvd11;
    logic [CODE_W-1:0] ch6_gain_code;
    logic              rsvd7;
    logic [CODE_W-1:0] ch5_gain_code;
    logic              rsvd3;
    logic [CODE_W-1:0] ch4_gain_code;
  } ucg_gain_reg_t;

  // One register port request as seen by the block.
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } ucg_req_t;

  // Power of two gain for a code: 000 gives 1, 111 gives 128.
  function automatic logic [GAIN_W-1:0] ucg_gain_of(input logic [CODE_W-1:0] code);
    ucg_gain_of = GAIN_UNITY << code;
  endfunction

  // Field code of one channel, channel 0 meaning channel 4.
  function automatic logic [CODE_W-1:0] ucg_field(input ucg_gain_reg_t r, input int idx);
    logic [CODE_W-1:0] f;
    f = r.ch4_gain_code;
    case (idx)
      1: f = r.ch5_gain_code;
      2: f = r.ch6_gain_code;
      3: f = r.ch7_gain_code;
      default: f = r.ch4_gain_code;
    endcase
    ucg_field = f;
  endfunction

endpackage

// File: hdl/ucg_chan.sv
// One channel gain field: stored code and its decoded gain factor.
`timescale 1ns/1ps
module ucg_chan
(
  input  wire logic                       mclk,
  input  wire logic                       sys_rst,
  input  wire logic                       load,
  input  wire logic [ucg_pkg::CODE_W-1:0] code_in,
  output logic      [ucg_pkg::CODE_W-1:0] gain_code,
  output logic      [ucg_pkg::GAIN_W-1:0] gain_factor
);

  logic [ucg_pkg::CODE_W-1:0] next_gain_code;
  logic [ucg_pkg::GAIN_W-1:0] next_gain_factor;

  // A load replaces the code; the factor follows in the same edge.
  always_comb
  begin
    next_gain_code   = gain_code;
    next_gain_factor = gain_factor;
    if (load)
    begin
      next_gain_code   = code_in;                        // R8
      next_gain_factor = ucg_pkg::ucg_gain_of(code_in);  // R8
    end
  end

  // Reset puts the channel at unity gain.
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      gain_code   <= ucg_pkg::CODE_RESET;  // R5
      gain_factor <= ucg_pkg::GAIN_UNITY;  // R5
    end
    else
    begin
      gain_code   <= next_gain_code;
      gain_factor <= next_gain_factor;
    end
  end

endmodule

// File: hdl/ucg_top.sv
// Upper channel gain register with per channel gain code and factor outputs.
//
// Local design decisions: the strobed register port and the register offsets.
`timescale 1ns/1ps
module ucg_top
(
  input  wire logic                       mclk,
  input  wire logic                       sys_rst,
  input  wire logic [ucg_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [ucg_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output logic      [ucg_pkg::DATA_W-1:0] reg_rdata,
  output logic      [ucg_pkg::CODE_W-1:0] ch4_gain_code,
  output logic      [ucg_pkg::CODE_W-1:0] ch5_gain_code,
  output logic      [ucg_pkg::CODE_W-1:0] ch6_gain_code,
  output logic      [ucg_pkg::CODE_W-1:0] ch7_gain_code,
  output logic      [ucg_pkg::GAIN_W-1:0] ch4_gain,
  output logic      [ucg_pkg::GAIN_W-1:0] ch5_gain,
  output logic      [ucg_pkg::GAIN_W-1:0] ch6_gain,
  output logic      [ucg_pkg::GAIN_W-1:0] ch7_gain,
  output logic                            gain_updated,
  output logic                            rsvd_write_seen
);

  // Request bundle built from the register port.
  ucg_pkg::ucg_req_t      req;
  ucg_pkg::ucg_gain_reg_t wr_view;
  ucg_pkg::ucg_gain_reg_t rd_view;

  logic                       hit_gain;
  logic                       hit_stat;
  logic                       gain_load;
  logic [ucg_pkg::CODE_W-1:0] code_q [ucg_pkg::NUM_CH];
  logic [ucg_pkg::GAIN_W-1:0] gain_q [ucg_pkg::NUM_CH];

  logic [ucg_pkg::DATA_W-1:0] next_reg_rdata;
  logic                       next_gain_updated;
  logic                       next_rsvd_write_seen;

  // Gather the port signals so the decode reads one bundle.
  assign req.wr    = reg_wr;
  assign req.rd    = reg_rd;
  assign req.addr  = reg_addr;
  assign req.wdata = reg_wdata;
  assign wr_view   = req.wdata;

  // Address decode for the two registers of the block.
  assign hit_gain  = (req.addr == ucg_pkg::UCG_GAIN_ADDR);  // R7
  assign hit_stat  = (req.addr == ucg_pkg::UCG_STAT_ADDR);
  assign gain_load = req.wr && hit_gain;

  // Each channel slice stores its own field of the gain register.
  for (genvar i = 0; i < ucg_pkg::NUM_CH; i++)
  begin : g_chan
    ucg_chan u_chan
    (
      .mclk        (mclk),
      .sys_rst     (sys_rst),
      .load        (gain_load),
      .code_in     (ucg_pkg::ucg_field(wr_view, i)),
      .gain_code   (code_q[i]),
      .gain_factor (gain_q[i])
    );
  end

  // Field placement of the stored codes; reserved bits always read zero.
  always_comb
  begin
    rd_view               = ucg_pkg::UCG_GAIN_RESET;
    rd_view.ch7_gain_code = code_q[3];  // R1
    rd_view.ch6_gain_code = code_q[2];  // R2
    rd_view.ch5_gain_code = code_q[1];  // R3
    rd_view.ch4_gain_code = code_q[0];  // R4
  end

  // Channel outputs come straight from the slice flip-flops.
  assign ch4_gain_code = code_q[0];  // R4
  assign ch5_gain_code = code_q[1];  // R3
  assign ch6_gain_code = code_q[2];  // R2
  assign ch7_gain_code = code_q[3];  // R1
  assign ch4_gain      = gain_q[0];  // R4
  assign ch5_gain      = gain_q[1];  // R3
  assign ch6_gain      = gain_q[2];  // R2
  assign ch7_gain      = gain_q[3];  // R1

  // Read data, update pulse and the sticky reserved write flag.
  always_comb
  begin
    next_reg_rdata       = '0;
    next_gain_updated    = gain_load;
    next_rsvd_write_seen = rsvd_write_seen;
    if (req.rd && hit_gain)
    begin
      next_reg_rdata = rd_view;  // R8
    end
    else if (req.rd && hit_stat)
    begin
      next_reg_rdata[ucg_pkg::STAT_RSVD_BIT] = rsvd_write_seen;
      next_rsvd_write_seen = 1'b0;
    end
    // A write that breaks the reserved bit convention is flagged; set wins over clear.
    if (gain_load && ((req.wdata & ucg_pkg::RSVD_MASK) != '0))
    begin
      next_rsvd_write_seen = 1'b1;  // R6
    end
  end

  // Registered answer side of the register port.
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      reg_rdata       <= '0;
      gain_updated    <= 1'b0;
      rsvd_write_seen <= 1'b0;
    end
    else
    begin
      reg_rdata       <= next_reg_rdata;
      gain_updated    <= next_gain_updated;
      rsvd_write_seen <= next_rsvd_write_seen;
    end
  end

endmodule

// File: bench/ucg_top_props.sv
// Port level checks for the upper channel gain register.
`timescale 1ns/1ps
module ucg_top_props
(
  input wire logic        mclk,
  input wire logic        sys_rst,
  input wire logic [5:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic [2:0]  ch4_gain_code,
  input wire logic [2:0]  ch5_gain_code,
  input wire logic [2:0]  ch6_gain_code,
  input wire logic [2:0]  ch7_gain_code,
  input wire logic [7:0]  ch4_gain,
  input wire logic [7:0]  ch5_gain,
  input wire logic [7:0]  ch6_gain,
  input wire logic [7:0]  ch7_gain,
  input wire logic        gain_updated
);
  // All checks share one clock and the asynchronous reset.
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // Stored codes in register layout, reserved bits as zero.
  wire [15:0] codes = {1'b0, ch7_gain_code, 1'b0, ch6_gain_code,
                       1'b0, ch5_gain_code, 1'b0, ch4_gain_code};
  sequence gain_wr;
    reg_wr && reg_addr == 6'h05;
  endsequence
  // Any cycle without a write to the gain register.
  sequence no_gain_wr;
    !(reg_wr && reg_addr == 6'h05);
  endsequence
  ch7_decode_a: assert property (ch7_gain == 8'h01 << ch7_gain_code)
    else $error("ch7 gain does not match its code");
  ch6_decode_a: assert property (ch6_gain == 8'h01 << ch6_gain_code)
    else $error("ch6 gain does not match its code");
  ch5_decode_a: assert property (ch5_gain == 8'h01 << ch5_gain_code)
    else $error("ch5 gain does not match its code");
  ch4_decode_a: assert property (ch4_gain == 8'h01 << ch4_gain_code)
    else $error("ch4 gain does not match its code");
  reset_codes_a: assert property ($fell(sys_rst) |-> codes == 16'h0000)
    else $error("codes not zero after reset");
  write_load_a: assert property (gain_wr |=> codes == ($past(reg_wdata) & 16'h7777))
    else $error("written codes not stored");
  code_hold_a: assert property (no_gain_wr |=> $stable(codes))
    else $error("codes changed without a write");
  read_back_a: assert property (reg_rd && reg_addr == 6'h05 |=> reg_rdata == codes)
    else $error("read data differs from stored codes");
  update_pulse_a: assert property (gain_wr |=> gain_updated)
    else $error("no update pulse after write");
  update_quiet_a: assert property (no_gain_wr |=> !gain_updated)
    else $error("update pulse without write");
endmodule
bind ucg_top ucg_top_props u_props (.mclk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .ch4_gain_code, .ch5_gain_code, .ch6_gain_code, .ch7_gain_code, .ch4_gain,
  .ch5_gain, .ch6_gain, .ch7_gain, .gain_updated);

// File: bench/upper_channel_gain_select_bench.sv
// Self-checking bench for the upper channel gain register.
`timescale 1ns/1ps
module upper_channel_gain_select_bench;
  logic        mclk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0;
  logic [5:0]  reg_addr = 6'h00;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata;
  logic [2:0]  c4, c5, c6, c7;
  logic [7:0]  g4, g5, g6, g7;
  logic        upd, seen;
  int          err_total = 0, cmp_count = 0;
  ucg_top DUT (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ch4_gain_code(c4),
    .ch5_gain_code(c5), .ch6_gain_code(c6), .ch7_gain_code(c7), .ch4_gain(g4), .ch5_gain(g5),
    .ch6_gain(g6), .ch7_gain(g7), .gain_updated(upd), .rsvd_write_seen(seen));
  // Free running 40 MHz clock.
  always #12.5 mclk = ~mclk;
  // Compares one result and counts it.
  task chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One register write, taken at the second edge.
  task wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
    #1;
  endtask
  // One register read, data checked in the cycle after the strobe.
  task rd(input logic [5:0] a, input logic [15:0] e);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  // Reset state of codes, gains and the whole register.
  task t_reset;
    chk({c7, c6, c5, c4, g7, g6, g5, g4}, {12'h000, 32'h01010101});
    rd(6'h05, 16'h0000);
  endtask
  // Every code in every field, decoded and read back.
  task t_codes;
    logic [2:0] k;
    for (int i = 0; i < 8; i++)
    begin
      k = 3'(i);
      wr(6'h05, {1'b0, k, 1'b0, k + 3'h1, 1'b0, k + 3'h2, 1'b0, k + 3'h3});
      chk(upd, 1'b1);
      chk({c7, g7}, {k, 8'h01 << k});
      chk({c6, g6}, {k + 3'h1, 8'h01 << (k + 3'h1)});
      chk({c5, g5}, {k + 3'h2, 8'h01 << (k + 3'h2)});
      chk({c4, g4}, {k + 3'h3, 8'h01 << (k + 3'h3)});
      rd(6'h05, {1'b0, k, 1'b0, k + 3'h1, 1'b0, k + 3'h2, 1'b0, k + 3'h3});
    end
  endtask
  // Reserved bits read zero and flag the write; unmapped space is inert.
  task t_rsvd;
    wr(6'h05, 16'hffff);
    chk(seen, 1'b1);
    rd(6'h05, 16'h7777);
    rd(6'h3f, 16'h0001);
    chk(seen, 1'b0);
    wr(6'h06, 16'h1234);
    chk(upd, 1'b0);
    rd(6'h06, 16'h0000);
    rd(6'h05, 16'h7777);
  endtask
  // A reset in mid-run brings loaded codes and the sticky flag back to their start values.
  task t_rerst;
    wr(6'h05, 16'hf777);
    chk(seen, 1'b1);
    @(posedge mclk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    #1 chk({c7, c6, c5, c4, g7, g6, g5, g4}, {12'h000, 32'h01010101});
    chk({upd, seen}, 2'b00);
    rd(6'h05, 16'h0000);
  endtask
  // Prints the verdict and ends the run.
  task results;
    if (err_total == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Main sequence after ten cycles of reset.
  initial
  begin
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    #1 t_reset;
    t_codes;
    t_rsvd;
    t_rerst;
    results;
  end
  // Watchdog well beyond the expected run of under a hundred cycles.
  initial
  begin
    #100us err_total++;
    results;
  end
endmodule
